// File: src/prc_top.sv
// periodic real-time counter with an axi4-lite register slave
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "prc_defs.svh"
module prc_top
  import prc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic low_power_osc_clock,
  input wire logic external_ref_clock,
  input wire logic internal_ref_clock,
  input wire logic [`PRC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`PRC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PRC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`PRC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  prc_state_t r;
  prc_state_t nx;
  logic [2:0] src_sync;
  logic sel_level;
  logic src_edge;
  logic tick;
  logic wrap;
  logic wr_fire;
  logic wr_sc;
  logic wr_cnt;
  logic wr_mod;
  logic [`PRC_PRE_W-1:0] ratio;

  prc_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({internal_ref_clock, external_ref_clock, low_power_osc_clock}),
    .sync_out(src_sync)
  );

  function automatic logic pick_src(input logic [1:0] sel, input logic [2:0] lv);
    case (sel)
      PRC_SRC_LOWPWR: pick_src = lv[0];
      PRC_SRC_EXT: pick_src = lv[1];
      default: pick_src = lv[2];
    endcase
  endfunction

  // scaled set for source bit 0
  function automatic logic [`PRC_PRE_W-1:0] div_ratio(input logic scale, input logic [3:0] ps);
    logic [`PRC_PRE_W-1:0] v;
    v = 18'h00001;
    case ({scale, ps})
      5'h01: v = 18'h00008;
      5'h02: v = 18'h00020;
      5'h03: v = 18'h00040;
      5'h04: v = 18'h00080;
      5'h05: v = 18'h00100;
      5'h06: v = 18'h00200;
      5'h07: v = 18'h00400;
      5'h08: v = 18'h00001;
      5'h09: v = 18'h00002;
      5'h0a: v = 18'h00004;
      5'h0b: v = 18'h0000a;
      5'h0c: v = 18'h00010;
      5'h0d: v = 18'h00064;
      5'h0e: v = 18'h001f4;
      5'h0f: v = 18'h003e8;
      5'h11: v = 18'h00400;
      5'h12: v = 18'h00800;
      5'h13: v = 18'h01000;
      5'h14: v = 18'h02000;
      5'h15: v = 18'h04000;
      5'h16: v = 18'h08000;
      5'h17: v = 18'h10000;
      5'h18: v = 18'h003e8;
      5'h19: v = 18'h007d0;
      5'h1a: v = 18'h01388;
      5'h1b: v = 18'h02710;
      5'h1c: v = 18'h04e20;
      5'h1d: v = 18'h0c350;
      5'h1e: v = 18'h186a0;
      5'h1f: v = 18'h30d40;
      default: v = 18'h00001;
    endcase
    return v;
  endfunction

  always_comb
  begin
    ratio = div_ratio(r.clock_source_select[0], r.divider_select);
    sel_level = pick_src(r.clock_source_select, src_sync);
    src_edge = sel_level && !r.src_prev && (r.divider_select != `PRC_PS_OFF);
    tick = src_edge && (r.pre == `PRC_PRE_W'(ratio - 18'h00001));
    wrap = tick && (r.count_value == r.compare_limit);
    wr_fire = r.aw_got && r.w_got && !r.bvalid;
    wr_sc = wr_fire && r.w_strb0 && (r.aw_addr == `PRC_OFF_SC);
    wr_cnt = wr_fire && r.w_strb0 && (r.aw_addr == `PRC_OFF_CNT);
    wr_mod = wr_fire && r.w_strb0 && (r.aw_addr == `PRC_OFF_MOD);
  end

  always_comb
  begin
    nx = r;
    // write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      nx.aw_got = 1'b1;
      nx.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nx.w_got = 1'b1;
      nx.w_data = s_axi_wdata;
      nx.w_strb0 = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready)
      nx.bvalid = 1'b0;
    if (src_edge)
    begin
      if (tick)
      begin
        nx.pre = '0;
        nx.count_value = wrap ? `PRC_CNT_RST : 8'(r.count_value + 8'h01);
      end
      else
        nx.pre = `PRC_PRE_W'(r.pre + 18'h00001);
    end
    if (wr_fire)
    begin
      nx.aw_got = 1'b0;
      nx.w_got = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = (r.aw_addr == `PRC_OFF_SC || r.aw_addr == `PRC_OFF_CNT || r.aw_addr == `PRC_OFF_MOD)
        ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
    end
    if (wr_sc)
    begin
      if (r.w_data[`PRC_SC_CLKS_HI:`PRC_SC_CLKS_LO] != r.clock_source_select
          || r.w_data[`PRC_SC_PS_HI:`PRC_SC_PS_LO] != r.divider_select)
      begin
        nx.pre = '0;
        nx.count_value = `PRC_CNT_RST;
      end
      nx.clock_source_select = r.w_data[`PRC_SC_CLKS_HI:`PRC_SC_CLKS_LO];
      nx.divider_select = r.w_data[`PRC_SC_PS_HI:`PRC_SC_PS_LO];
      nx.match_irq_enable = r.w_data[`PRC_SC_IE];
      if (r.w_data[`PRC_SC_FLAG])
        nx.match_flag = 1'b0;
    end
    if (wr_mod)
    begin
      nx.compare_limit = r.w_data[7:0];
      nx.pre = '0;
      nx.count_value = `PRC_CNT_RST;
    end
    // set on the wrap step, wins over a clear
    if (wrap)
      nx.match_flag = 1'b1;
    // old level of the new source, so a switch makes no false edge
    nx.src_prev = pick_src(nx.clock_source_select, src_sync);
    // read channel, one read at a time
    if (r.rvalid && s_axi_rready)
      nx.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      nx.rvalid = 1'b1;
      nx.rresp = `PRC_RESP_OKAY;
      case (s_axi_araddr)
        `PRC_OFF_SC: nx.rdata = {24'h000000, r.match_flag, r.clock_source_select,
          r.match_irq_enable, r.divider_select};
        `PRC_OFF_CNT: nx.rdata = {24'h000000, r.count_value};
        `PRC_OFF_MOD: nx.rdata = {24'h000000, r.compare_limit};
        default:
        begin
          nx.rdata = '0;
          nx.rresp = `PRC_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.clock_source_select <= `PRC_CLKS_RST;
      r.divider_select <= `PRC_PS_RST;
      r.count_value <= `PRC_CNT_RST;
      r.compare_limit <= `PRC_MOD_RST;
    end
    else
      r <= nx;
  end

  // a held response blocks new writes; simple, costs no throughput at one outstanding
  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign irq = r.match_flag && r.match_irq_enable;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_reset_state;
    disable iff (1'b0)
    !aresetn |=> (r.count_value == 8'h00 && r.compare_limit == 8'h00 && r.divider_select == 4'h0
      && r.pre == '0 && !r.match_flag && !r.match_irq_enable);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_reset_src;
    disable iff (1'b0)
    !aresetn |=> r.clock_source_select == 2'h0;
  endproperty
  a_reset_src: assert property (p_reset_src) else $error("reset source not low-power");

  property p_off_idle;
    r.divider_select == 4'h0 |-> (r.pre == '0 && r.count_value == 8'h00 && !tick);
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("counting while off");

  property p_src_map;
    sel_level == (r.clock_source_select == 2'h0 ? src_sync[0] :
      r.clock_source_select == 2'h1 ? src_sync[1] : src_sync[2]);
  endproperty
  a_src_map: assert property (p_src_map) else $error("wrong source selected");

  property p_src_hi;
    r.clock_source_select[1] |-> sel_level == src_sync[2];
  endproperty
  a_src_hi: assert property (p_src_hi) else $error("1x not internal");

  sequence s_src_change;
    wr_sc && r.w_data[6:5] != r.clock_source_select;
  endsequence
  property p_src_clear;
    s_src_change |=> (r.count_value == 8'h00 && r.pre == '0);
  endproperty
  a_src_clear: assert property (p_src_clear) else $error("source change kept count");

  sequence s_ps_change;
    wr_sc && r.w_data[3:0] != r.divider_select;
  endsequence
  property p_ps_clear;
    s_ps_change |=> (r.count_value == 8'h00 && r.pre == '0);
  endproperty
  a_ps_clear: assert property (p_ps_clear) else $error("divider change kept count");

  property p_pre_bound;
    r.divider_select != 4'h0 |-> r.pre < div_ratio(r.clock_source_select[0], r.divider_select);
  endproperty
  a_pre_bound: assert property (p_pre_bound) else $error("prescaler past ratio");

  property p_ratio_1s;
    (r.clock_source_select == 2'h0 && r.divider_select == 4'hf) |-> ratio == 18'h003e8;
  endproperty
  a_ratio_1s: assert property (p_ratio_1s) else $error("1 s ratio wrong");

  property p_mod_write;
    wr_mod |=> (r.compare_limit == $past(r.w_data[7:0]) && r.count_value == 8'h00 && r.pre == '0);
  endproperty
  a_mod_write: assert property (p_mod_write) else $error("limit write wrong");

  property p_step;
    (tick && !wrap && !wr_fire) |=> r.count_value == 8'($past(r.count_value) + 8'h01);
  endproperty
  a_step: assert property (p_step) else $error("counter did not step");

  sequence s_wrap;
    tick && r.count_value == r.compare_limit;
  endsequence
  property p_wrap;
    s_wrap |=> (r.match_flag && (r.count_value == 8'h00 || $past(wr_fire)));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not flag");

  property p_no_early_flag;
    (!r.match_flag && !wrap) |=> !r.match_flag;
  endproperty
  a_no_early_flag: assert property (p_no_early_flag) else $error("flag set without wrap");

  property p_limit0;
    (tick && r.compare_limit == 8'h00) |=> r.match_flag;
  endproperty
  a_limit0: assert property (p_limit0) else $error("zero limit missed flag");

  property p_full_range;
    (tick && r.compare_limit == 8'hff && r.count_value == 8'hfe && !wr_fire) |=> r.count_value == 8'hff;
  endproperty
  a_full_range: assert property (p_full_range) else $error("limit ff not reached");

  property p_irq;
    irq == (r.match_flag && r.match_irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_w1c;
    (wr_sc && r.w_data[7] && !wrap) |=> (!r.match_flag && !irq);
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_w0;
    (r.match_flag && wr_sc && !r.w_data[7]) |=> r.match_flag;
  endproperty
  a_w0: assert property (p_w0) else $error("write 0 cleared flag");

  property p_cnt_ro;
    (wr_cnt && !tick) |=> $stable(r.count_value);
  endproperty
  a_cnt_ro: assert property (p_cnt_ro) else $error("count written");
endmodule

// File: src/prc_defs.svh
// offsets, field positions, reset values and widths of the periodic counter
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH
`define PRC_ADDR_W 8
`define PRC_DATA_W 32
`define PRC_OFF_SC 8'h00
`define PRC_OFF_CNT 8'h04
`define PRC_OFF_MOD 8'h08
`define PRC_SC_FLAG 7
`define PRC_SC_CLKS_HI 6
`define PRC_SC_CLKS_LO 5
`define PRC_SC_IE 4
`define PRC_SC_PS_HI 3
`define PRC_SC_PS_LO 0
`define PRC_CLKS_RST 2'h0
`define PRC_PS_RST 4'h0
`define PRC_PS_OFF 4'h0
`define PRC_CNT_RST 8'h00
`define PRC_MOD_RST 8'h00
`define PRC_PRE_W 18
`define PRC_RESP_OKAY 2'h0
`define PRC_RESP_SLVERR 2'h2
`endif

// File: src/prc_pkg.sv
// types shared by the periodic counter modules
package prc_pkg;
`include "prc_defs.svh"

  typedef enum logic [1:0] {
    PRC_SRC_LOWPWR = 2'h0,
    PRC_SRC_EXT = 2'h1,
    PRC_SRC_INT = 2'h2,
    PRC_SRC_INT_ALT = 2'h3
  } prc_src_t;

  typedef struct packed {
    logic [2:0] stage1;
    logic [2:0] stage2;
  } prc_sync_t;

  typedef struct packed {
    logic aw_got;
    logic [`PRC_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [`PRC_DATA_W-1:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [`PRC_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic match_flag;
    logic [1:0] clock_source_select;
    logic match_irq_enable;
    logic [3:0] divider_select;
    logic [7:0] compare_limit;
    logic [7:0] count_value;
    logic [`PRC_PRE_W-1:0] pre;
    logic src_prev;
  } prc_state_t;
endpackage

// File: src/prc_sync.sv
// two-stage synchroniser for the three counting clock pins
`timescale 1ns/100ps
module prc_sync
  import prc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);
  prc_sync_t r;
  prc_sync_t nx;

  always_comb
  begin
    nx = r;
    nx.stage1 = async_in;
    nx.stage2 = r.stage1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= nx;
  end

  // only the second stage leaves the module
  assign sync_out = r.stage2;
endmodule

// File: test/prc_testbench.sv
// self-checking bench for the periodic counter register slave
`timescale 1ns/100ps
`include "prc_defs.svh"
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [2:0] src = 3'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int bad_count = 0;
  int checks = 0;

  always #12.5 aclk = ~aclk;

  prc_top DUT (
    .aclk(aclk), .aresetn(aresetn),
    .low_power_osc_clock(src[0]), .external_ref_clock(src[1]), .internal_ref_clock(src[2]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // master holds each channel until its own handshake edge
  // no local limit: only the watchdog ends a wait that never completes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `PRC_RESP_OKAY);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = `PRC_RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, exp);
    chk(rresp, er);
  endtask

  // source period six aclk, well above the two-cycle minimum
  task automatic pulse(input int p, input int k);
    repeat (k)
    begin
      @(posedge aclk);
      src[p] <= 1'b1;
      repeat (3) @(posedge aclk);
      src[p] <= 1'b0;
      repeat (2) @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
  endtask

  task automatic t_reset;
    rd(`PRC_OFF_SC, 32'h0);
    rd(`PRC_OFF_CNT, 32'h0);
    rd(`PRC_OFF_MOD, 32'h0);
    chk(irq, 1'b0);
    pulse(0, 4);
    rd(`PRC_OFF_CNT, 32'h0);
  endtask

  // limit 0xff keeps the count from wrapping during the ratio run
  task automatic t_ratio(input logic [1:0] s, input logic [3:0] code, input int e);
    int p;
    p = s[1] ? 2 : int'(s[0]);
    wr(`PRC_OFF_MOD, 32'h0000_00ff);
    wr(`PRC_OFF_SC, {25'h0, s, 1'b0, code});
    pulse(p, e - 1);
    rd(`PRC_OFF_CNT, 32'h0);
    pulse(p, 1);
    rd(`PRC_OFF_CNT, 32'h1);
  endtask

  task automatic t_clear;
    wr(`PRC_OFF_SC, 32'h08);
    pulse(0, 3);
    wr(`PRC_OFF_SC, 32'h08);
    rd(`PRC_OFF_CNT, 32'h3);
    wr(`PRC_OFF_MOD, 32'hff);
    rd(`PRC_OFF_CNT, 32'h0);
    pulse(0, 2);
    rd(`PRC_OFF_CNT, 32'h2);
    wr(`PRC_OFF_SC, 32'h09);
    rd(`PRC_OFF_CNT, 32'h0);
    pulse(0, 2);
    wr(`PRC_OFF_CNT, 32'h55);
    rd(`PRC_OFF_CNT, 32'h1);
    wr(`PRC_OFF_SC, 32'h29);
    rd(`PRC_OFF_CNT, 32'h0);
  endtask

  task automatic t_match;
    wr(`PRC_OFF_MOD, 32'h02);
    wr(`PRC_OFF_SC, 32'h18);
    pulse(0, 2);
    rd(`PRC_OFF_CNT, 32'h2);
    rd(`PRC_OFF_SC, 32'h18);
    chk(irq, 1'b0);
    pulse(0, 1);
    rd(`PRC_OFF_CNT, 32'h0);
    rd(`PRC_OFF_SC, 32'h98);
    chk(irq, 1'b1);
    wr(`PRC_OFF_SC, 32'h18);
    rd(`PRC_OFF_SC, 32'h98);
    wr(`PRC_OFF_SC, 32'h98);
    rd(`PRC_OFF_SC, 32'h18);
    chk(irq, 1'b0);
    wr(`PRC_OFF_MOD, 32'h00);
    wr(`PRC_OFF_SC, 32'h08);
    pulse(0, 1);
    rd(`PRC_OFF_SC, 32'h88);
    chk(irq, 1'b0);
    wr(`PRC_OFF_SC, 32'h88);
    rd(`PRC_OFF_SC, 32'h08);
    pulse(0, 1);
    rd(`PRC_OFF_SC, 32'h88);
    rd(`PRC_OFF_CNT, 32'h0);
  endtask

  task automatic t_unmapped;
    wr(8'h0c, 32'hff, `PRC_RESP_SLVERR);
    rd(8'h0c, 32'h0, `PRC_RESP_SLVERR);
    rd(`PRC_OFF_MOD, 32'h0);
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_ratio(2'h0, 4'h1, 8);
    t_ratio(2'h0, 4'hb, 10);
    t_ratio(2'h1, 4'h8, 1000);
    t_ratio(2'h1, 4'h1, 1024);
    t_ratio(2'h2, 4'h8, 1);
    t_ratio(2'h3, 4'h8, 1000);
    t_clear();
    t_match();
    t_unmapped();
    end_of_test();
  end

  // whole run is near 19000 cycles
  initial
  begin
    repeat (80000) @(posedge aclk);
    bad_count++;
    end_of_test();
  end
endmodule
